// File: rtl/ssi_regs.svh
/*
  register addresses, field positions, reset values and timing counts of the serial shift interface.
  assumes a 125 MHz system clock and a 7-bit register file address.
*/
// Operation
// RULE_01: MSB out on fall, LSB in on rise
// RULE_02: no shifting at all while waiting
// RULE_03: cpu loads and reads register via buffer
// RULE_04: two-wire shifts only at counts one to eight
// RULE_05: ninth received bit goes to ack flag
// RULE_06: ack flag driven on data at count nine
// RULE_07: same behaviour for any shift clock source
// RULE_08: transmitted bus level shifts back in
// RULE_09: serial mode shifts regardless of counter
// RULE_10: plain storage use keeps wait set
// RULE_11: access only with clock high or waiting
// RULE_12: internal clock waits at eighth rising edge
// RULE_13: external peer holds clock high during access
// RULE_14: interrupt source select at address 38h
// RULE_15: its upper two bits read zero
// RULE_16: select seventh, eighth, post-start seventh, stop
// RULE_17: shift clock rate register at address 39h
// RULE_18: its upper two bits read zero
// RULE_19: rate codes 100k, 200k, 500k, 1M
// RULE_20: wait point none, eight, nine, address
// RULE_21: write 0 forces wait, 1 releases
// RULE_22: one single-cycle request per interrupt event
`ifndef SSI_REGS_SVH
`define SSI_REGS_SVH

`define SSI_RF_IRQ_SEL   7'h38
`define SSI_RF_RATE      7'h39
`define SSI_RF_WAIT      7'h3a

`define SSI_WAIT_ACK_BIT 3
`define SSI_WAIT_REL_BIT 2
`define SSI_RST_SEL      2'h0
`define SSI_RST_ACK      1'b0

`define SSI_CLK_HZ       125000000
`define SSI_RATE0_HZ     100000
`define SSI_RATE1_HZ     200000
`define SSI_RATE2_HZ     500000
`define SSI_RATE3_HZ     1000000

`define SSI_CNT_IRQ_A    4'h7
`define SSI_CNT_DATA     4'h8
`define SSI_CNT_ACK      4'h9

`endif

// File: rtl/ssi_pkg.sv
/*
  types shared by the serial shift interface.
  assumes nothing of its surroundings.
*/
package ssi_pkg;
  // wait point codes
  typedef enum logic [1:0] {
    SSI_WAIT_NONE = 2'h0,
    SSI_WAIT_DATA = 2'h1,
    SSI_WAIT_ACK  = 2'h2,
    SSI_WAIT_ADDR = 2'h3
  } ssi_wait_t;
  // interrupt point codes
  typedef enum logic [1:0] {
    SSI_IRQ_BIT7  = 2'h0,
    SSI_IRQ_BIT8  = 2'h1,
    SSI_IRQ_START = 2'h2,
    SSI_IRQ_STOP  = 2'h3
  } ssi_irq_t;
  typedef logic [3:0] ssi_cnt_t;
endpackage

// File: rtl/ssi_sync2.sv
/*
  two flip-flop level synchroniser, parameterised width.
  assumes each bit is an independent level or toggle.
*/
`timescale 1ns/1ps
`default_nettype none
module ssi_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstN,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule // ssi_sync2
`default_nettype wire

// File: rtl/ssi_serial_shift.sv
/*
  serial shift interface core: preset shift register, clock counter, wait and ack
  handling, interrupt point and internal shift clock generator.
  assumes the shift clock pin level arrives on shiftClk, that mode bits come from
  logic on clk_sys, and that the bench resolves open-drain wires from the enables.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssi_regs.svh"
module ssi_serial_shift
  import ssi_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       shiftClk,
  input  wire logic       modeTwoWire,
  input  wire logic       txMode,
  input  wire logic       intClkEn,
  input  wire logic [6:0] rfAddr,
  input  wire logic       rfWe,
  input  wire logic       rfRe,
  input  wire logic [3:0] rfWrData,
  output var  logic [3:0] rfRdData,
  input  wire logic       dbfPut,
  input  wire logic       dbfGet,
  input  wire logic [7:0] dbfWrData,
  output var  logic [7:0] dbfRdData,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output var  logic       sdaOeN,
  input  wire logic       siIn,
  output var  logic       soOut,
  output var  logic       sckOut,
  output var  logic       sckOeN,
  output var  logic       irqReq,
  output logic            waitStatus
);

  // half period of the internal clock, rounded up so the rate never exceeds the figure
  function automatic logic [9:0] halfCount(input logic [1:0] sel);
    int rate;
    rate = `SSI_RATE0_HZ;
    case (sel)
      2'h0: rate = `SSI_RATE0_HZ;
      2'h1: rate = `SSI_RATE1_HZ;
      2'h2: rate = `SSI_RATE2_HZ;
      default: rate = `SSI_RATE3_HZ;
    endcase
    return 10'((`SSI_CLK_HZ + 2 * rate - 1) / (2 * rate));
  endfunction

  logic [1:0] rstSync_r;
  logic       rstSyncN;
  logic       riseTgl_r;
  logic       fallTgl_r;
  logic       sampSda_r;
  logic       sampSi_r;
  logic [3:0] syncQ;
  logic       riseSeen_r;
  logic       fallSeen_r;
  logic       sdaPrev_r;
  logic [7:0] psr_r;
  logic [7:0] psrNxt;
  ssi_cnt_t   cnt_r;
  ssi_cnt_t   cntNxt;
  logic       ackFlag_r;
  logic       ackNxt;
  logic       waitActive_r;
  logic       waitNxt;
  ssi_wait_t  waitSel_r;
  ssi_irq_t   irqSel_r;
  logic [1:0] rateSel_r;
  logic       firstByte_r;
  logic       sdaDrv_r;
  logic [9:0] genCnt_r;
  logic       sckGen_r;

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) rstSync_r <= 2'h0;
    else       rstSync_r <= {rstSync_r[0], 1'b1};
  end
  assign rstSyncN = rstSync_r[1];

  // link side: the pin clock itself marks its edges, data sampled at the real rising edge
  always_ff @(posedge shiftClk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      riseTgl_r <= 1'b0;
      sampSda_r <= 1'b1;
      sampSi_r  <= 1'b1;
    end else begin
      riseTgl_r <= ~riseTgl_r;
      sampSda_r <= sdaIn; // RULE_08
      sampSi_r  <= siIn;
    end
  end

  // falling edge event, separate process so no flop sees both edges
  always_ff @(negedge shiftClk or negedge rstSyncN) begin
    if (!rstSyncN) fallTgl_r <= 1'b0;
    else           fallTgl_r <= ~fallTgl_r;
  end

  // levels cross inverted so the synchroniser's zero reset matches idle-high pins, no false stop
  ssi_sync2 #(.W(4)) uSync (
    .clk  (clk_sys),
    .rstN (rstSyncN),
    .d    ({riseTgl_r, fallTgl_r, ~sdaIn, ~shiftClk}),
    .q    (syncQ)
  ); // RULE_07

  // event decode; sampled data is stable until the next rise, 48 ns away at least
  wire riseEv    = syncQ[3] ^ riseSeen_r;
  wire fallEv    = syncQ[2] ^ fallSeen_r;
  wire sdaLvl    = ~syncQ[1];
  wire sclLvl    = ~syncQ[0];
  wire startDet  = modeTwoWire & sclLvl & sdaPrev_r & ~sdaLvl;
  wire stopDet   = modeTwoWire & sclLvl & ~sdaPrev_r & sdaLvl;
  wire shiftRise = riseEv & ~waitActive_r; // RULE_02
  wire shiftFall = fallEv & ~waitActive_r; // RULE_02
  wire sampBit   = modeTwoWire ? sampSda_r : sampSi_r;

  // register file decode
  wire wrIrq   = rfWe & (rfAddr == `SSI_RF_IRQ_SEL); // RULE_14
  wire wrRate  = rfWe & (rfAddr == `SSI_RF_RATE); // RULE_17
  wire wrWait  = rfWe & (rfAddr == `SSI_RF_WAIT);

  // serial mode shifts regardless of the counter; two-wire shifts at counts one to eight only
  wire inByte  = (cnt_r >= 4'h1) & (cnt_r <= `SSI_CNT_DATA);
  wire shiftEn = modeTwoWire ? inByte : 1'b1; // RULE_04 RULE_09
  wire ackSlot = cnt_r == `SSI_CNT_ACK;

  // clock counter advances on falls, so the count is k from the fall before bit k
  wire [3:0] cntInc = (cnt_r == `SSI_CNT_ACK) ? 4'h1 : cnt_r + 4'h1;
  always_comb begin
    cntNxt = cnt_r;
    if (startDet || (wrWait && !modeTwoWire))
      cntNxt = 4'h0;
    else if (shiftFall)
      cntNxt = cntInc;
  end

  // a buffer store wins over a shift; software is told to store only while stalled
  always_comb begin
    psrNxt = psr_r;
    if (dbfPut)
      psrNxt = dbfWrData; // RULE_03
    else if (shiftRise && shiftEn)
      psrNxt = {psr_r[6:0], sampBit}; // RULE_01 RULE_08 RULE_09
  end

  // ninth bit of a received frame lands in the ack flag; hardware capture beats a write
  wire ackCap = modeTwoWire & ~txMode & shiftRise & ackSlot;
  assign ackNxt = ackCap ? sampSda_r : // RULE_05
                  wrWait ? rfWrData[`SSI_WAIT_ACK_BIT] : ackFlag_r;

  // wait points: two-wire on the falling edge, serial mode at the high level after a rise
  wire [3:0] waitCnt = (waitSel_r == SSI_WAIT_ACK) ? `SSI_CNT_ACK : `SSI_CNT_DATA;
  wire waitArmed = (waitSel_r == SSI_WAIT_DATA) | (waitSel_r == SSI_WAIT_ACK) |
                   ((waitSel_r == SSI_WAIT_ADDR) & modeTwoWire & firstByte_r);
  wire waitHit   = waitArmed & (modeTwoWire ? (shiftFall & (cntNxt == waitCnt))
                                            : (shiftRise & (cnt_r == waitCnt))); // RULE_20
  // set by the wait point wins over a release written in the same cycle
  assign waitNxt = waitHit ? 1'b1 : wrWait ? ~rfWrData[`SSI_WAIT_REL_BIT] : waitActive_r; // RULE_21
  assign waitStatus = waitActive_r;

  // interrupt point selection
  wire irq7  = shiftRise & (cnt_r == `SSI_CNT_IRQ_A);
  wire irq8  = shiftRise & (cnt_r == `SSI_CNT_DATA);
  logic irqHit;
  always_comb begin
    case (irqSel_r)
      SSI_IRQ_BIT7:  irqHit = irq7;
      SSI_IRQ_BIT8:  irqHit = irq8;
      SSI_IRQ_START: irqHit = irq7 & firstByte_r;
      SSI_IRQ_STOP:  irqHit = stopDet;
      default:       irqHit = 1'b0;
    endcase
  end // RULE_16

  // edge bookkeeping and start/stop history
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      riseSeen_r <= 1'b0;
      fallSeen_r <= 1'b0;
      sdaPrev_r  <= 1'b1;
    end else begin
      riseSeen_r <= syncQ[3];
      fallSeen_r <= syncQ[2];
      sdaPrev_r  <= sdaLvl;
    end
  end

  // shift register, counter, flags
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      psr_r        <= 8'h00;
      cnt_r        <= 4'h0;
      ackFlag_r    <= `SSI_RST_ACK;
      waitActive_r <= 1'b1;
    end else begin
      psr_r        <= psrNxt;
      cnt_r        <= cntNxt;
      ackFlag_r    <= ackNxt;
      waitActive_r <= waitNxt;
    end
  end

  // software-written selects; only the low two bits exist
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      irqSel_r  <= SSI_IRQ_BIT7;
      rateSel_r <= `SSI_RST_SEL;
      waitSel_r <= SSI_WAIT_NONE;
    end else begin
      if (wrIrq)  irqSel_r  <= ssi_irq_t'(rfWrData[1:0]);
      if (wrRate) rateSel_r <= rfWrData[1:0];
      if (wrWait) waitSel_r <= ssi_wait_t'(rfWrData[1:0]);
    end
  end

  // first byte after a start, ends once the count reaches nine
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN)                                        firstByte_r <= 1'b0;
    else if (startDet)                                    firstByte_r <= 1'b1;
    else if (stopDet || (shiftFall && cntInc == `SSI_CNT_ACK)) firstByte_r <= 1'b0;
  end

  // one pulse per event, events themselves last one cycle
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) irqReq <= 1'b0;
    else           irqReq <= irqHit; // RULE_22
  end

  // data line: byte bits from the MSB, ack flag at count nine, released otherwise
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      sdaDrv_r <= 1'b1;
      soOut    <= 1'b1;
    end else begin
      if (!modeTwoWire || startDet || stopDet)
        sdaDrv_r <= 1'b1;
      else if (shiftFall && cntInc == `SSI_CNT_ACK)
        sdaDrv_r <= ackFlag_r; // RULE_06
      else if (shiftFall)
        sdaDrv_r <= txMode ? psr_r[7] : 1'b1; // RULE_01
      if (shiftFall && !modeTwoWire)
        soOut <= psr_r[7]; // RULE_01
    end
  end
  assign sdaOut = 1'b0;
  assign sdaOeN = sdaDrv_r;

  // internal clock: halted while waiting, low in two-wire and high in serial mode
  wire [9:0] halfCnt = halfCount(rateSel_r); // RULE_19
  wire       genWrap = genCnt_r >= halfCnt - 10'h1;
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      genCnt_r <= 10'h000;
      sckGen_r <= 1'b1;
    end else if (!intClkEn) begin
      genCnt_r <= 10'h000;
      sckGen_r <= 1'b1;
    end else if (!waitActive_r) begin
      genCnt_r <= genWrap ? 10'h000 : genCnt_r + 10'h001;
      if (genWrap) sckGen_r <= ~sckGen_r;
    end
  end

  // clock pin drive: open drain with slave stretch in two-wire, push-pull in serial mode
  wire slaveHold = modeTwoWire & ~intClkEn & waitActive_r & (waitSel_r != SSI_WAIT_NONE);
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      sckOut <= 1'b1;
      sckOeN <= 1'b1;
    end else if (modeTwoWire) begin
      sckOut <= 1'b0;
      sckOeN <= ~((intClkEn & ~sckGen_r) | slaveHold);
    end else begin
      sckOut <= sckGen_r;
      sckOeN <= ~intClkEn;
    end
  end

  // registered reads; unmapped addresses answer zero
  always_ff @(posedge clk_sys or negedge rstSyncN) begin
    if (!rstSyncN) begin
      rfRdData  <= 4'h0;
      dbfRdData <= 8'h00;
    end else begin
      if (rfRe) begin
        case (rfAddr)
          `SSI_RF_IRQ_SEL: rfRdData <= {2'h0, irqSel_r}; // RULE_15
          `SSI_RF_RATE:    rfRdData <= {2'h0, rateSel_r}; // RULE_18
          `SSI_RF_WAIT:    rfRdData <= {ackFlag_r, ~waitActive_r, waitSel_r};
          default:         rfRdData <= 4'h0;
        endcase
      end
      if (dbfGet) dbfRdData <= psr_r; // RULE_03
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstSyncN);

  sequence byteFall;
    modeTwoWire && txMode && shiftFall && !startDet && !stopDet && cnt_r < `SSI_CNT_DATA;
  endsequence

  sequence ackFall;
    modeTwoWire && shiftFall && !startDet && !stopDet && cnt_r == `SSI_CNT_DATA;
  endsequence

  no_shift_wait_a: assert property (waitActive_r && !dbfPut |=> $stable(psr_r)) // RULE_02
    else $error("shift register moved while waiting");
  buffer_load_a: assert property (dbfPut |=> psr_r == $past(dbfWrData)) // RULE_03
    else $error("buffer store not taken");
  buffer_read_a: assert property (dbfGet |=> dbfRdData == $past(psr_r)) // RULE_03
    else $error("buffer load returned wrong value");
  count_gate_a: assert property (modeTwoWire && riseEv && !inByte && !dbfPut |=> $stable(psr_r)) // RULE_04
    else $error("shift outside counts one to eight");
  shift_in_a: assert property (shiftRise && shiftEn && !dbfPut |=> psr_r == {$past(psr_r[6:0]), $past(sampBit)}) // RULE_01
    else $error("sampled bit not shifted into lsb");
  ack_capture_a: assert property (ackCap |=> ackFlag_r == $past(sampSda_r)) // RULE_05
    else $error("ninth bit not stored in ack flag");
  ack_drive_a: assert property (ackFall |=> sdaOeN == $past(ackFlag_r) ##1 sdaOeN == $past(ackFlag_r, 2)) // RULE_06
    else $error("ack flag not on data line at count nine");
  msb_drive_a: assert property (byteFall |=> sdaOeN == $past(psr_r[7])) // RULE_01
    else $error("msb not driven after falling edge");
  irq_hi_zero_a: assert property (rfRe && rfAddr == `SSI_RF_IRQ_SEL |=> rfRdData[3:2] == 2'h0) // RULE_15
    else $error("interrupt select upper bits not zero");
  rate_hi_zero_a: assert property (rfRe && rfAddr == `SSI_RF_RATE |=> rfRdData[3:2] == 2'h0) // RULE_18
    else $error("rate upper bits not zero");
  irq_seventh_a: assert property (irqSel_r == SSI_IRQ_BIT7 && irq7 |=> irqReq ##1 !irqReq) // RULE_16
    else $error("seventh edge request missing or long");
  irq_single_a: assert property (irqReq |=> !irqReq) // RULE_22
    else $error("interrupt request longer than one cycle");
  wait_force_a: assert property (wrWait && !rfWrData[`SSI_WAIT_REL_BIT] |=> waitActive_r ##1 (waitActive_r || $past(wrWait))) // RULE_21
    else $error("forced wait not applied");
  wait_point_a: assert property (modeTwoWire && shiftFall && waitSel_r == SSI_WAIT_ACK && cntNxt == `SSI_CNT_ACK |=> waitActive_r) // RULE_20
    else $error("acknowledge wait not taken");
  rate_toggle_a: assert property (intClkEn && !waitActive_r && genCnt_r == halfCnt - 10'h1 |=> sckGen_r != $past(sckGen_r)) // RULE_19
    else $error("internal clock half period wrong");

endmodule // ssi_serial_shift
`default_nettype wire

// File: dv/ssi_peer_model.sv
/*
  far-side peer: external serial i/o clock source and two-wire bus master.
  assumes the bench resolves the open-drain wires from the drive levels given here.
*/
`timescale 1ns/1ps
`default_nettype none
module ssi_peer_model (
  output var logic sclDrv,
  output var logic sdaDrv,
  output var logic siOut,
  input  wire logic sdaWire,
  input  wire logic soIn
);
  logic [7:0] seen;
  logic [8:0] seen9;
  // idle: clock high, data released
  initial begin
    sclDrv = 1'h1;
    sdaDrv = 1'h1;
    siOut  = 1'h0;
  end
  // one 48 ns clock; long low phase so the core's synced output lands before the rise
  task automatic pulse(input logic d);
    sclDrv = 1'h0;
    #12;
    sdaDrv = d;
    siOut  = d;
    #22;
    sclDrv = 1'h1;
    #14;
    seen  = {seen[6:0], soIn};
    seen9 = {seen9[7:0], sdaWire};
  endtask
  // serial i/o frame; clock then idles high while software reaches the register
  task automatic serial8(input logic [7:0] din);
    #3.3;
    for (int i = 7; i >= 0; i--) pulse(din[i]);
    sclDrv = 1'h1;
    sdaDrv = 1'h1;
  endtask
  // two-wire start then nine clocks; a 1 in drv releases data
  task automatic bits9(input logic [8:0] drv);
    #3.3;
    sdaDrv = 1'h0;
    #48;
    for (int i = 8; i >= 0; i--) pulse(drv[i]);
    sclDrv = 1'h0;
    #12;
    sdaDrv = 1'h0;
  endtask
  // stop: data rises while clock high
  task automatic stop();
    #24;
    sclDrv = 1'h1;
    #48;
    sdaDrv = 1'h1;
    #48;
  endtask
endmodule // ssi_peer_model
`default_nettype wire

// File: dv/tb_top.sv
/*
  self-checking bench of the serial shift core: registers, buffer, serial i/o, two-wire frames, clock rates.
  assumes the peer model drives the link and the open-drain wires resolve here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ssi_regs.svh"
module tb_top
  import ssi_pkg::*;
;
  logic       clk_sys = 1'h0, rstn = 1'h0, modeTwoWire = 1'h0, txMode = 1'h0, intClkEn = 1'h0;
  logic       rfWe = 1'h0, rfRe = 1'h0, dbfPut = 1'h0, dbfGet = 1'h0;
  logic [6:0] rfAddr = 7'h00;
  logic [3:0] rfWrData = 4'h0, rfRdData, d4;
  logic [7:0] dbfWrData = 8'h00, dbfRdData, d8;
  logic       sdaOut, sdaOeN, soOut, sckOut, sckOeN, irqReq, waitStatus, sclDrv, sdaDrv, siIn;
  wire        shiftClk, sdaIn;
  int         failures = 0, num_checks = 0, cycles = 0, irqCnt = 0;
  // open-drain wires: whoever pulls low wins
  assign shiftClk = sclDrv & (sckOeN | sckOut);
  assign sdaIn    = sdaDrv & (sdaOeN | sdaOut);
  ssi_serial_shift uut (
    .clk_sys(clk_sys), .rstn(rstn), .shiftClk(shiftClk), .modeTwoWire(modeTwoWire), .txMode(txMode),
    .intClkEn(intClkEn), .rfAddr(rfAddr), .rfWe(rfWe), .rfRe(rfRe), .rfWrData(rfWrData),
    .rfRdData(rfRdData), .dbfPut(dbfPut), .dbfGet(dbfGet), .dbfWrData(dbfWrData), .dbfRdData(dbfRdData),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .siIn(siIn), .soOut(soOut), .sckOut(sckOut),
    .sckOeN(sckOeN), .irqReq(irqReq), .waitStatus(waitStatus)
  );
  ssi_peer_model peer (.sclDrv(sclDrv), .sdaDrv(sdaDrv), .siOut(siIn), .sdaWire(sdaIn), .soIn(soOut));
  always #4 clk_sys = ~clk_sys;
  // irq cycles counted so a stretched pulse shows; ceiling is a few times the longest run
  always @(posedge clk_sys) begin
    cycles++;
    if (irqReq === 1'h1) irqCnt++;
    if (cycles == 80000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'h1) begin
      failures++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  // one register file access; read data lands a cycle after the strobe
  task automatic rf_op(input logic we, input logic [6:0] a, input logic [3:0] d);
    @(posedge clk_sys);
    rfAddr   <= a;
    rfWrData <= d;
    rfWe     <= we;
    rfRe     <= ~we;
    @(posedge clk_sys);
    rfWe     <= 1'h0;
    rfRe     <= 1'h0;
    #1 d4 = rfRdData;
  endtask
  task automatic buf_op(input logic isPut, input logic [7:0] d);
    @(posedge clk_sys);
    dbfWrData <= d;
    dbfPut    <= isPut;
    dbfGet    <= ~isPut;
    @(posedge clk_sys);
    dbfPut    <= 1'h0;
    dbfGet    <= 1'h0;
    #1 d8 = dbfRdData;
  endtask
  task automatic wr_wait(input logic ack, input logic rel, input ssi_wait_t sel);
    rf_op(1'h1, `SSI_RF_WAIT, {ack, rel, sel});
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic t_regs();
    rf_op(1'h0, `SSI_RF_IRQ_SEL, 4'h0);
    chk(d4 === 4'h0, "irq sel reset");
    rf_op(1'h0, `SSI_RF_RATE, 4'h0);
    chk(d4 === 4'h0, "rate reset");
    rf_op(1'h1, `SSI_RF_IRQ_SEL, 4'hf);
    rf_op(1'h0, `SSI_RF_IRQ_SEL, 4'h0);
    chk(d4 === 4'h3, "irq sel upper bits");
    rf_op(1'h1, `SSI_RF_RATE, 4'he);
    rf_op(1'h0, `SSI_RF_RATE, 4'h0);
    chk(d4 === 4'h2, "rate upper bits");
    rf_op(1'h1, 7'h20, 4'hf);
    rf_op(1'h0, 7'h20, 4'h0);
    chk(d4 === 4'h0, "unmapped read");
    rf_op(1'h1, `SSI_RF_IRQ_SEL, 4'h0);
    chk(waitStatus === 1'h1, "wait after reset");
    wr_wait(1'h0, 1'h1, SSI_WAIT_NONE);
    chk(waitStatus === 1'h0, "wait release");
  endtask
  // external serial clock: shift in, msb first out, then forced wait blocks shifting
  task automatic t_serial();
    buf_op(1'h1, 8'h3c);
    wr_wait(1'h0, 1'h1, SSI_WAIT_NONE);
    peer.serial8(8'h96);
    repeat (8) @(posedge clk_sys);
    buf_op(1'h0, 8'h00);
    chk(d8 === 8'h96, "serial receive");
    chk(peer.seen === 8'h3c, "serial out order");
    wr_wait(1'h0, 1'h0, SSI_WAIT_NONE);
    peer.serial8(8'h5a);
    repeat (8) @(posedge clk_sys);
    buf_op(1'h0, 8'h00);
    chk(d8 === 8'h96, "shifted while waiting");
  endtask
  // two-wire receive: ack flag released so the peer's ninth bit reaches it
  task automatic t_rx();
    modeTwoWire <= 1'h1;
    wr_wait(1'h1, 1'h1, SSI_WAIT_NONE);
    irqCnt = 0;
    peer.bits9({8'hc3, 1'h0});
    repeat (8) @(posedge clk_sys);
    buf_op(1'h0, 8'h00);
    chk(d8 === 8'hc3, "receive data");
    rf_op(1'h0, `SSI_RF_WAIT, 4'h0);
    chk(d4[3] === 1'h0, "ack capture");
    peer.stop();
    repeat (8) @(posedge clk_sys);
    chk(irqCnt === 1, "irq seventh rise");
  endtask
  // two-wire transmit with a collision on bit 3 in the middle frame
  task automatic t_tx();
    ssi_irq_t   codes [3] = '{SSI_IRQ_BIT8, SSI_IRQ_START, SSI_IRQ_STOP};
    logic [7:0] drv   [3] = '{8'hff, 8'hf7, 8'hff};
    logic [7:0] exp;
    wr_wait(1'h0, 1'h1, SSI_WAIT_NONE);
    for (int k = 0; k < 3; k++) begin
      exp = 8'hda & drv[k];
      txMode <= 1'h1;
      buf_op(1'h1, 8'hda);
      rf_op(1'h1, `SSI_RF_IRQ_SEL, {2'h0, codes[k]});
      irqCnt = 0;
      peer.bits9({drv[k], 1'h1});
      repeat (8) @(posedge clk_sys);
      buf_op(1'h0, 8'h00);
      chk(d8 === exp, "bus read back");
      chk(peer.seen9 === {exp, 1'h0}, "wire data and ack");
      txMode <= 1'h0;
      peer.stop();
      repeat (8) @(posedge clk_sys);
      chk(irqCnt === 1, "irq pulse per event");
    end
  endtask
  // two-wire slave receive with ack wait: clock held low, release lets the ninth rise in
  task automatic t_wait();
    modeTwoWire <= 1'h1;
    wr_wait(1'h1, 1'h1, SSI_WAIT_ACK);
    peer.bits9({8'ha5, 1'h1});
    repeat (8) @(posedge clk_sys);
    buf_op(1'h0, 8'h00);
    chk(d8 === 8'ha5, "data before ack wait");
    chk(waitStatus === 1'h1 && sckOeN === 1'h0, "ack wait stretch");
    wr_wait(1'h1, 1'h1, SSI_WAIT_NONE);
    peer.stop();
    repeat (8) @(posedge clk_sys);
    rf_op(1'h0, `SSI_RF_WAIT, 4'h0);
    chk(d4 === 4'h4, "ack taken after release");
  endtask
  // cycles between two clock pin toggles, sampled just after each edge
  task automatic edge_gap(output int n);
    logic s;
    s = sckOut;
    n = 0;
    while (sckOut === s && n < 2000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask
  task automatic t_rate();
    int halves [4] = '{625, 313, 125, 63};
    int n;
    modeTwoWire <= 1'h0;
    intClkEn    <= 1'h1;
    for (int r = 0; r < 4; r++) begin
      rf_op(1'h1, `SSI_RF_RATE, 4'(r));
      wr_wait(1'h0, 1'h1, SSI_WAIT_DATA);
      edge_gap(n);
      edge_gap(n);
      chk(n === halves[r], "half period");
      n = 0;
      while (waitStatus !== 1'h1 && n < 12000) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      chk(waitStatus === 1'h1 && sckOut === 1'h1, "wait high at eight");
    end
    intClkEn <= 1'h0;
    wr_wait(1'h0, 1'h0, SSI_WAIT_NONE);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'h1;
    repeat (4) @(posedge clk_sys);
    t_regs();
    t_serial();
    t_rx();
    t_tx();
    t_wait();
    t_rate();
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
